/* File: rtl/led_i2c_target.sv */
// Bus target: address decode, control byte capture and pointer stepping
`timescale 1ns/1ps
`default_nettype none
module led_i2c_target
    import led_i2c_pkg::*;
#(
    parameter logic [6:0] SOFT_RESET_ADDR = 7'h03
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Serial bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe_o,
    // Hardware address straps
    input  wire logic [6:0]  pin_address_i,
    // Register bank outside this block
    output var  reg_req_type reg_req_o,
    input  wire logic [7:0]  reg_rdata_i,
    // Software reset call seen
    output var  logic        reset_call_o
);

    // Synchronised pins
    logic       scl_s;
    logic       sda_s;
    logic [6:0] pin_s;
    logic       scl_d;
    logic       sda_d;

    // Sequencer state
    bus_state_type state;
    bus_state_type next_state;
    logic [3:0]    cnt;
    logic [3:0]    next_cnt;
    logic [7:0]    shift;
    logic [7:0]    next_shift;
    logic [7:0]    tx;
    logic [7:0]    next_tx;
    logic          read_mode;
    logic          next_read_mode;
    logic          is_reset_call;
    logic          next_is_reset_call;
    logic          next_sda_oe;
    logic          next_reset_call;
    reg_req_type   next_req;

    // Stored registers
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [4:0] mode_low;
    logic [4:0] next_mode_low;
    logic [7:0] group_call_address;
    logic [7:0] next_group_call_address;
    logic [7:0] sub_call_address_1;
    logic [7:0] next_sub_call_address_1;
    logic [7:0] sub_call_address_2;
    logic [7:0] next_sub_call_address_2;
    logic [7:0] sub_call_address_3;
    logic [7:0] next_sub_call_address_3;

    // Decode helpers
    logic       start_cond;
    logic       stop_cond;
    logic       scl_rise;
    logic       scl_fall;
    logic [6:0] addr7;
    logic       dir_read;
    logic       hit_pin;
    logic       hit_group;
    logic       hit_sub;
    logic       hit_reset;
    logic [7:0] rd_byte;
    logic [4:0] ptr_next;

    // Bus lines idle high, so they reset high to avoid a false START
    sync_2ff #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync_bus (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({scl_i, sda_i}),
        .q_o    ({scl_s, sda_s})
    );

    // Straps may change at any time, so they are synchronised too
    sync_2ff #(.WIDTH(7), .RESET_VAL(7'h00)) u_sync_pin (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (pin_address_i),
        .q_o    (pin_s)
    );

    // Delayed copies for edge detection
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Bus conditions and edges
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;

    // Address compare, call addresses ignore their own LSB
    assign addr7     = shift[7:1];
    assign dir_read  = shift[0];
    assign hit_pin   = (addr7 == pin_s);
    assign hit_group = mode_low[MODE_GROUP_BIT]
                       & (addr7 == group_call_address[7:1]);
    assign hit_sub   = (mode_low[MODE_SUB1_BIT] & (addr7 == sub_call_address_1[7:1]))
                     | (mode_low[MODE_SUB2_BIT] & (addr7 == sub_call_address_2[7:1]))
                     | (mode_low[MODE_SUB3_BIT] & (addr7 == sub_call_address_3[7:1]));
    assign hit_reset = (addr7 == SOFT_RESET_ADDR) & ~dir_read;

    // Pointer step for the current scheme
    ptr_step u_ptr_step (
        .ptr_i    (ctrl[4:0]),
        .scheme_i (ctrl[7:CTRL_SCHEME_LSB]),
        .ptr_o    (ptr_next)
    );

    // Read data: local registers here, the rest from outside
    always_comb begin
        case (ctrl[4:0])
            PTR_MODE:       rd_byte = {ctrl[7:CTRL_SCHEME_LSB], mode_low};
            PTR_SUB1:       rd_byte = sub_call_address_1;
            PTR_SUB2:       rd_byte = sub_call_address_2;
            PTR_SUB3:       rd_byte = sub_call_address_3;
            PTR_GROUP_CALL: rd_byte = group_call_address;
            default:        rd_byte = reg_rdata_i;
        endcase
    end

    // Sequencer next state; SDA only changes while SCL is low
    always_comb begin
        next_state              = state;
        next_cnt                = cnt;
        next_shift              = shift;
        next_tx                 = tx;
        next_read_mode          = read_mode;
        next_is_reset_call      = is_reset_call;
        next_sda_oe             = sda_oe_o;
        next_reset_call         = 1'b0;
        next_ctrl               = ctrl;
        next_mode_low           = mode_low;
        next_group_call_address = group_call_address;
        next_sub_call_address_1 = sub_call_address_1;
        next_sub_call_address_2 = sub_call_address_2;
        next_sub_call_address_3 = sub_call_address_3;
        next_req                = reg_req_o;
        next_req.wr             = 1'b0;
        if (start_cond) begin
            next_state  = ST_ADDR;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (state)
                ST_ADDR, ST_CTRL, ST_WDATA: begin
                    next_shift = {shift[6:0], sda_s};
                    next_cnt   = cnt + 4'h1;
                end
                ST_RDATA: begin
                    next_cnt = cnt + 4'h1;
                end
                ST_RACK: begin
                    // Controller NACK ends the read
                    if (sda_s) begin
                        next_state = ST_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (cnt == BYTE_BITS) begin
                        if (hit_pin | hit_group | hit_sub | hit_reset) begin
                            next_sda_oe        = 1'b1;
                            next_state         = ST_AACK;
                            next_read_mode     = dir_read;
                            next_is_reset_call = hit_reset & ~(hit_pin | hit_group | hit_sub);
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end
                end
                ST_AACK: begin
                    next_sda_oe = 1'b0;
                    next_cnt    = 4'h0;
                    if (is_reset_call) begin
                        next_reset_call = 1'b1;
                        next_state      = ST_WAIT;
                    end else if (read_mode) begin
                        next_sda_oe = ~rd_byte[7];
                        next_tx     = {rd_byte[6:0], 1'b0};
                        next_state  = ST_RDATA;
                    end else begin
                        next_state = ST_CTRL;
                    end
                end
                ST_CTRL: begin
                    if (cnt == BYTE_BITS) begin
                        if (shift[4:0] <= PTR_LAST) begin
                            next_ctrl   = shift;
                            next_sda_oe = 1'b1;
                            next_state  = ST_CACK;
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end
                end
                ST_CACK, ST_DACK: begin
                    next_sda_oe = 1'b0;
                    next_cnt    = 4'h0;
                    next_state  = ST_WDATA;
                end
                ST_WDATA: begin
                    if (cnt == BYTE_BITS) begin
                        next_sda_oe   = 1'b1;
                        next_state    = ST_DACK;
                        next_req.wr   = 1'b1;
                        next_req.data = shift;
                        case (ctrl[4:0])
                            PTR_MODE:       next_mode_low           = shift[4:0];
                            PTR_SUB1:       next_sub_call_address_1 = shift;
                            PTR_SUB2:       next_sub_call_address_2 = shift;
                            PTR_SUB3:       next_sub_call_address_3 = shift;
                            PTR_GROUP_CALL: next_group_call_address = shift;
                            default: begin
                            end
                        endcase
                        next_ctrl[4:0] = ptr_next;
                    end
                end
                ST_RDATA: begin
                    if (cnt == BYTE_BITS) begin
                        next_sda_oe    = 1'b0;
                        next_state     = ST_RACK;
                        next_ctrl[4:0] = ptr_next;
                    end else begin
                        next_sda_oe = ~tx[7];
                        next_tx     = {tx[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    // Acknowledged: present the next byte
                    next_cnt    = 4'h0;
                    next_sda_oe = ~rd_byte[7];
                    next_tx     = {rd_byte[6:0], 1'b0};
                    next_state  = ST_RDATA;
                end
                default: begin
                end
            endcase
        end
        // Write address shows the pointer in force for the byte
        if (!next_req.wr) begin
            next_req.addr = next_ctrl[4:0];
        end else begin
            next_req.addr = ctrl[4:0];
        end
    end

    // Sequencer and register storage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state              <= ST_IDLE;
            cnt                <= 4'h0;
            shift              <= 8'h00;
            tx                 <= 8'h00;
            read_mode          <= 1'b0;
            is_reset_call      <= 1'b0;
            sda_oe_o           <= 1'b0;
            sda_o              <= 1'b0;
            reset_call_o       <= 1'b0;
            reg_req_o          <= '0;
            ctrl               <= CTRL_RST;
            mode_low           <= MODE_LOW_RST;
            group_call_address <= GROUP_CALL_RST;
            sub_call_address_1 <= SUB1_RST;
            sub_call_address_2 <= SUB2_RST;
            sub_call_address_3 <= SUB3_RST;
        end else begin
            state              <= next_state;
            cnt                <= next_cnt;
            shift              <= next_shift;
            tx                 <= next_tx;
            read_mode          <= next_read_mode;
            is_reset_call      <= next_is_reset_call;
            sda_oe_o           <= next_sda_oe;
            sda_o              <= 1'b0;
            reset_call_o       <= next_reset_call;
            reg_req_o          <= next_req;
            ctrl               <= next_ctrl;
            mode_low           <= next_mode_low;
            group_call_address <= next_group_call_address;
            sub_call_address_1 <= next_sub_call_address_1;
            sub_call_address_2 <= next_sub_call_address_2;
            sub_call_address_3 <= next_sub_call_address_3;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/led_i2c_pkg.sv */
// Shared constants and types for the LED driver bus target
package led_i2c_pkg;

    // Register pointer positions
    localparam logic [4:0] PTR_FIRST      = 5'h00;
    localparam logic [4:0] PTR_MODE       = 5'h00;
    localparam logic [4:0] PTR_BRIGHT_LO  = 5'h02;
    localparam logic [4:0] PTR_BRIGHT_HI  = 5'h11;
    localparam logic [4:0] PTR_GROUP_LO   = 5'h12;
    localparam logic [4:0] PTR_GROUP_HI   = 5'h13;
    localparam logic [4:0] PTR_SUB1       = 5'h18;
    localparam logic [4:0] PTR_SUB2       = 5'h19;
    localparam logic [4:0] PTR_SUB3       = 5'h1A;
    localparam logic [4:0] PTR_GROUP_CALL = 5'h1B;
    localparam logic [4:0] PTR_LAST       = 5'h1B;

    // Increment scheme codes, top three bits of the control byte
    localparam logic [2:0] SCHEME_NONE    = 3'h0;
    localparam logic [2:0] SCHEME_ALL     = 3'h4;
    localparam logic [2:0] SCHEME_BRIGHT  = 3'h5;
    localparam logic [2:0] SCHEME_GLOBAL  = 3'h6;
    localparam logic [2:0] SCHEME_BOTH    = 3'h7;

    // Field positions
    localparam int CTRL_SCHEME_LSB = 5;
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int MODE_SUB1_BIT   = 3;
    localparam int MODE_SUB2_BIT   = 2;
    localparam int MODE_SUB3_BIT   = 1;
    localparam int MODE_GROUP_BIT  = 0;

    // Values after reset
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [4:0] MODE_LOW_RST   = 5'h11;
    localparam logic [7:0] GROUP_CALL_RST = 8'hE0;
    localparam logic [7:0] SUB1_RST       = 8'hE2;
    localparam logic [7:0] SUB2_RST       = 8'hE4;
    localparam logic [7:0] SUB3_RST       = 8'hE8;

    // Bits per byte on the wire
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Write request towards the register bank outside this block
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] data;
    } reg_req_type;

    // Bus target sequence
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_CTRL, ST_CACK,
        ST_WDATA, ST_DACK, ST_RDATA, ST_RACK, ST_WAIT
    } bus_state_type;

endpackage

/* File: rtl/sync_2ff.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= RESET_VAL;
            q_o  <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/ptr_step.sv */
// Next register pointer for the auto-increment schemes
`timescale 1ns/1ps
`default_nettype none
module ptr_step
    import led_i2c_pkg::*;
(
    // Current pointer and scheme
    input  wire logic [4:0] ptr_i,
    input  wire logic [2:0] scheme_i,
    // Pointer after one byte
    output var  logic [4:0] ptr_o
);

    logic [4:0] last;
    logic [4:0] wrap;

    // Window ends per scheme
    always_comb begin
        last = PTR_LAST;
        wrap = PTR_FIRST;
        case (scheme_i)
            SCHEME_ALL: begin
                last = PTR_LAST;
                wrap = PTR_FIRST;
            end
            SCHEME_BRIGHT: begin
                last = PTR_BRIGHT_HI;
                wrap = PTR_BRIGHT_LO;
            end
            SCHEME_GLOBAL: begin
                last = PTR_GROUP_HI;
                wrap = PTR_GROUP_LO;
            end
            SCHEME_BOTH: begin
                last = PTR_GROUP_HI;
                wrap = PTR_BRIGHT_LO;
            end
            default: begin
                last = PTR_LAST;
                wrap = PTR_FIRST;
            end
        endcase
    end

    // Reserved codes have the enable bit low, so they hold like 000
    always_comb begin
        if (!scheme_i[2]) begin
            ptr_o = ptr_i;
        end else if (ptr_i == last) begin
            ptr_o = wrap;
        end else if (ptr_i >= PTR_LAST) begin
            ptr_o = PTR_FIRST;
        end else begin
            ptr_o = ptr_i + 5'h01;
        end
    end

endmodule
`default_nettype wire

/* File: test/led_i2c_target_sva.sv */
// Port checker for the LED driver bus target
`timescale 1ns/1ps
`default_nettype none
module led_i2c_target_sva
    import led_i2c_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // Bus pins and straps
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic [6:0]  pin_address_i,
    // Register side
    input wire reg_req_type reg_req_o,
    input wire logic [7:0]  reg_rdata_i,
    input wire logic        reset_call_o
);
    // One domain, so one clock and one reset for all
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Open drain: the pin is only ever pulled low
    a_only_pull_low: assert property (!sda_o)
        else $error("sda drive value not low");
    a_quiet_after_reset: assert property ($rose(nrst_i) |-> !sda_oe_o [*3])
        else $error("sda pulled right after reset");
    a_pull_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
        else $error("sda pull too short");
    a_write_pulse: assert property (reg_req_o.wr |=> !reg_req_o.wr)
        else $error("write strobe longer than one cycle");
    a_write_in_range: assert property (reg_req_o.wr |-> reg_req_o.addr <= PTR_LAST)
        else $error("write to reserved pointer");
    a_write_acked: assert property (reg_req_o.wr |-> ##[0:6] sda_oe_o)
        else $error("written byte not acknowledged");
    a_data_holds: assert property (reg_req_o.wr |=> $stable(reg_req_o.data) [*8])
        else $error("write data moved");
    a_call_pulse: assert property (reset_call_o |=> !reset_call_o)
        else $error("reset call pulse too long");
    a_call_no_write: assert property (reset_call_o |-> !reg_req_o.wr [*8])
        else $error("write after reset call");
    // Pull changes follow a low clock pin seen through the two flop stages
    a_pull_while_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 3))
        else $error("sda pull changed while clock high");
endmodule

bind led_i2c_target led_i2c_target_sva u_sva (
    .clk_i, .nrst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .pin_address_i, .reg_req_o, .reg_rdata_i, .reset_call_o
);
`default_nettype wire

/* File: test/i2c_ctrl_model.sv */
// Bus controller model driving clock and data toward the target
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
    // Wire level seen on the data line
    input  wire logic sda_i,
    // Open drain drives, one means released
    output var  logic scl_o,
    output var  logic sda_o
);
    int slow = 0;
    // Idle bus: both lines released
    initial {scl_o, sda_o} = 2'b11;
    // One bit from SCL low; data moves a step after the fall to avoid a false START
    task automatic xbit(input logic b, output logic r);
        #(25 + 25 * slow) sda_o = b;
        #100 scl_o = 1'b1;
        #50 r = sda_i;
        #25 scl_o = 1'b0;
    endtask
    // START, always followed by an address byte
    task automatic start();
        #25 sda_o = 1'b1;
        #100 scl_o = 1'b1;
        #100 sda_o = 1'b0;
        #100 scl_o = 1'b0;
    endtask
    task automatic stop();
        #25 sda_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #100;
    endtask
    // Byte MSB first, then acknowledge bit a; k is one when acknowledged
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(a, r);
        k = ~r;
    endtask
endmodule
`default_nettype wire

/* File: test/i2c_address_decode_pointer_bench.sv */
// Self-checking bench: address decode, control byte capture, pointer stepping
`timescale 1ns/1ps
`default_nettype none
module i2c_address_decode_pointer_bench;
    import led_i2c_pkg::*;
    localparam logic [6:0] SOFT = 7'h03;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [6:0]  pin = 7'h20;
    logic        scl;
    logic        sda_m;
    logic        sda_oe;
    logic        rcall;
    reg_req_type req;
    logic [7:0]  rdata;
    logic [31:0] lf = 32'h00010BA7;
    logic [7:0]  sub[6] = '{8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8, 8'hE9};
    int          mismatches = 0;
    int          checks = 0;
    int          ncall = 0;
    logic [12:0] seen[$];
    wire logic   sda = sda_m & ~sda_oe; // Pull-up unless someone pulls low
    // Outside bank answers with the pointer so reads are traceable
    assign rdata = {3'h5, req.addr};

    led_i2c_target #(.SOFT_RESET_ADDR(SOFT)) DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .pin_address_i(pin), .reg_req_o(req),
        .reg_rdata_i(rdata), .reset_call_o(rcall)
    );
    i2c_ctrl_model m (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));

    always #12.5 clk_i = ~clk_i;
    // Record register writes and reset call pulses
    always @(posedge clk_i) begin
        if (req.wr === 1'b1) seen.push_back({req.addr, req.data});
        if (rcall === 1'b1) ncall++;
    end

    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    // Expected pointer after one byte under a scheme
    function automatic logic [4:0] nxt(logic [4:0] p, logic [2:0] s);
        logic [4:0] hi = s[1] ? 5'h13 : (s[0] ? 5'h11 : 5'h1B);
        logic [4:0] lo = (s[1:0] == 2'b10) ? 5'h12 : {3'h0, |s[1:0], 1'b0};
        if (!s[2]) return p;
        return (p == hi) ? lo : ((p == 5'h1B) ? 5'h00 : p + 5'h01);
    endfunction
    // Data that keeps mode and call registers at their reset meaning
    function automatic logic [7:0] safe(logic [4:0] p);
        logic [7:0] keep[4] = '{SUB1_RST, SUB2_RST, SUB3_RST, GROUP_CALL_RST};
        if (p == PTR_MODE) return 8'h01;
        return (p >= PTR_SUB1) ? keep[p[1:0]] : rnd();
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic go(input logic [7:0] a, output logic k);
        logic [7:0] q;
        m.start();
        m.xfer(a, 1'b1, q, k);
    endtask
    // Address only; an answered read takes one byte and a NACK to free the bus
    task automatic probe(input logic [7:0] a, input logic e);
        logic [7:0] q;
        logic k;
        go(a, k);
        check(16'(k), 16'(e), "address answer");
        if (k && a[0]) m.xfer(8'hFF, 1'b1, q, k);
        m.stop();
    endtask
    task automatic wone(input logic [4:0] p, input logic [7:0] d);
        logic [7:0] q;
        logic k;
        go({pin, 1'b0}, k);
        m.xfer({3'h0, p}, 1'b1, q, k);
        m.xfer(d, 1'b1, q, k);
        m.stop();
    endtask
    // Control byte then n data bytes, pointer and data checked per byte
    task automatic wseq(input logic [7:0] c, input int n);
        logic [7:0] q;
        logic [4:0] p;
        logic k;
        logic [12:0] ex[$];
        seen.delete();
        m.slow = int'(rnd() % 8'h02); // Sometimes a slow controller
        go({pin, 1'b0}, k);
        m.xfer(c, 1'b1, q, k);
        check(16'(k), 16'h0001, "control accepted");
        p = c[4:0];
        for (int i = 0; i < n; i++) begin
            ex.push_back({p, safe(p)});
            m.xfer(ex[i][7:0], 1'b1, q, k);
            p = nxt(p, c[7:5]);
        end
        m.stop();
        check(16'(seen.size()), 16'(n), "write count");
        foreach (ex[i]) check(16'(seen[i]), 16'(ex[i]), "step");
    endtask

    initial begin
        logic k;
        logic [7:0] q;
        logic [7:0] c[5];
        repeat (6) @(negedge clk_i);
        pin = 7'h20 | 7'(rnd() & 8'h1F); // Off reserved and call ranges
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // Pointer 1Bh with scheme 100, then read across the wrap
        go({pin, 1'b0}, k);
        m.xfer(8'h9B, 1'b1, q, k);
        go({pin, 1'b1}, k);
        check(16'(k), 16'h0001, "read address");
        m.xfer(8'hFF, 1'b0, q, k);
        check(16'(q), 16'(GROUP_CALL_RST), "group call reset");
        m.xfer(8'hFF, 1'b0, q, k);
        check(16'(q), 16'({SCHEME_ALL, MODE_LOW_RST}), "mode and scheme");
        m.xfer(8'hFF, 1'b1, q, k);
        check(16'(q), 16'h00A1, "outside register");
        m.stop();
        // Decode with reset enables
        probe({pin, 1'b0}, 1'b1);
        probe({pin, 1'b1}, 1'b1);
        probe(GROUP_CALL_RST, 1'b1);
        probe(8'hE1, 1'b1);
        foreach (sub[i]) probe(sub[i], 1'b0);
        probe({SOFT, 1'b1}, 1'b0);
        probe({SOFT, 1'b0}, 1'b1);
        probe({2'b10, 5'(rnd()), 1'b0}, 1'b0);
        check(16'(ncall), 16'h0001, "reset call count");
        // Every documented scheme, starting just before, on or past the window edge
        c = '{{3'h0, 5'(rnd() % 8'h1C)}, 8'h9A, 8'hB1, 8'hD3, 8'hFA};
        foreach (c[i]) wseq(c[i], 3 + int'(rnd() % 8'h03));
        // Enable every sub call, then move sub call 2 and the group call address
        wone(PTR_MODE, 8'h0F);
        probe(SUB1_RST, 1'b1);
        probe(SUB2_RST | 8'h01, 1'b1);
        probe(SUB3_RST, 1'b1);
        wone(PTR_SUB2, 8'hC4);
        probe(8'hC5, 1'b1);
        probe(SUB2_RST, 1'b0);
        wone(PTR_GROUP_CALL, 8'hD0);
        probe(GROUP_CALL_RST, 1'b0);
        probe(8'hD1, 1'b1);
        for (int i = 28; i < 32; i++) begin
            go({pin, 1'b0}, k);
            m.xfer(8'(i), 1'b1, q, k);
            check(16'(k), 16'h0000, "reserved pointer");
            m.stop();
        end
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
